// ===== core/drive_panel_pkg.sv
// Constants, register map and state codes for the drive panel block.
// Assumes a 125 MHz mclk and a single AHB-Lite slave select.
package drive_panel_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_KHZ          = 125_000;
   localparam int SEEK_TIMEOUT_MS  = 90;
   localparam int RECAL_TIMEOUT_MS = 1250;
   localparam int SEEK_TIMEOUT_CYC  = SEEK_TIMEOUT_MS * CLK_KHZ;
   localparam int RECAL_TIMEOUT_CYC = RECAL_TIMEOUT_MS * CLK_KHZ;
   localparam int TMR_W            = 28;

   // ----------------------------------------
   // Synchronised input vector bit positions
   // ----------------------------------------
   localparam int IN_RUN      = 0;
   localparam int IN_RO       = 1;
   localparam int IN_STOPPED  = 2;
   localparam int IN_SPEED    = 3;
   localparam int IN_LOADED   = 4;
   localparam int IN_RETRACT  = 5;
   localparam int IN_SEEK     = 6;
   localparam int IN_RECAL    = 7;
   localparam int IN_RWF      = 8;
   localparam int IN_SERVO    = 9;
   localparam int IN_PSU      = 10;
   localparam int IN_CB       = 11;
   localparam int IN_PCA      = 12;
   localparam int IN_PACKF    = 13;
   localparam int IN_AC       = 14;
   localparam int IN_SEL      = 15;
   localparam int IN_UNIT_LSB = 16;
   localparam int UNIT_W      = 3;
   localparam int NIN         = IN_UNIT_LSB + UNIT_W;
   localparam int DIGIT_W     = 4;
   localparam logic [3:0] DIGIT_EIGHT = 4'h8;

   // ----------------------------------------
   // Fault causes and interrupt events
   // ----------------------------------------
   localparam int FC_SEEK = 0;
   localparam int FC_RECAL = 1;
   localparam int FC_RW = 2;
   localparam int FC_SERVO = 3;
   localparam int FC_PSU = 4;
   localparam int FC_CB = 5;
   localparam int FC_PCA = 6;
   localparam int NFC = 7;
   localparam int EV_FAULT = 0;
   localparam int EV_READY = 1;
   localparam int EV_DOOR = 2;
   localparam int EV_SELECT = 3;
   localparam int NEV = 4;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam int AW = 8;
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_FAULT    = 8'h08;
   localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
   localparam logic [7:0] REG_IRQ_CLR  = 8'h10;
   localparam logic [7:0] REG_IRQ_EN   = 8'h14;
   localparam int CTRL_WP = 0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [2:0] {
      ST_STOPPED = 3'b000,
      ST_SPINUP  = 3'b001,
      ST_LOAD    = 3'b010,
      ST_READY   = 3'b011,
      ST_RETRACT = 3'b100,
      ST_BRAKE   = 3'b101
   } seq_t;
endpackage

// ===== core/drive_panel.sv
// Operator panel sequencing, fault latch and lamps of a pack disc drive.
// Assumes asynchronous panel and sensor pins and an AHB-Lite master on mclk.
`timescale 1ns/1ps
module drive_panel #(
   parameter int SEEK_LIMIT  = drive_panel_pkg::SEEK_TIMEOUT_CYC,  // Seek timeout cycles
   parameter int RECAL_LIMIT = drive_panel_pkg::RECAL_TIMEOUT_CYC  // Recal timeout cycles
) (
   input  wire logic        mclk,              // 125 MHz clock
   input  wire logic        rst,               // Sync reset, high
   input  wire logic        hsel,              // AHB select
   input  wire logic [31:0] haddr,             // AHB address
   input  wire logic [1:0]  htrans,            // AHB transfer type
   input  wire logic        hwrite,            // AHB write
   input  wire logic [2:0]  hsize,             // AHB size, word only
   input  wire logic [31:0] hwdata,            // AHB write data
   input  wire logic        hready,            // AHB bus ready
   output logic      [31:0] hrdata,            // AHB read data
   output logic             hreadyout,         // AHB slave ready
   output logic             hresp,             // AHB response, OKAY
   input  wire logic        run_sw,            // Run/stop at run
   input  wire logic        read_only_sw,      // Read-only protected
   input  wire logic        spindle_stopped,   // Spindle at rest
   input  wire logic        spindle_at_speed,  // Spindle at speed
   input  wire logic        heads_loaded,      // Heads on cylinder zero
   input  wire logic        heads_retracted,   // Carriage at rest
   input  wire logic        seek_busy,         // Seek in progress
   input  wire logic        recal_busy,        // Recalibrate in progress
   input  wire logic        rw_fault,          // Read/write malfunction
   input  wire logic        servo_lost,        // Servo level missing
   input  wire logic        psu_fail,          // Supply failure
   input  wire logic        carriage_blocked,  // Carriage-back not clear
   input  wire logic        board_unplugged,   // Board not seated
   input  wire logic        pack_det_fault,    // Pack detector faulty
   input  wire logic        ac_power_ok,       // Ac at supplies
   input  wire logic        host_select,       // Cable select line
   input  wire logic [2:0]  unit_sw,           // Rotary unit address
   output logic             spindle_power,     // Spindle motor on
   output logic             spindle_brake,     // Spindle brake on
   output logic             head_load,         // Load heads command
   output logic             head_retract,      // Retract heads command
   output logic             door_solenoid,     // Door unlock solenoid
   output logic             door_unlocked_lamp,// Door unlocked lamp
   output logic             drive_ready_lamp,  // Drive ready lamp
   output logic             drive_fault_lamp,  // Drive fault lamp
   output logic             read_only_lamp,    // Read-only lamp
   output logic             write_inhibit,     // Global write block
   output logic [3:0]       unit_digit,        // Unit display digit
   output logic             unit_display_on,   // Unit display lit
   output logic             select_lamp,       // Select lamp
   output logic             irq                // Interrupt, level high
);
   localparam int N = drive_panel_pkg::NIN;

   logic [N-1:0] pin_raw;
   logic [N-1:0] s1_r, s2_r, s3_r, in_r;
   logic         run_s, stopped_s, speed_s, loaded_s;
   logic [drive_panel_pkg::UNIT_W-1:0] unit_s;
   logic         run_prev_r, run_rise;
   drive_panel_pkg::seq_t seq_r, seq_nxt;
   logic [drive_panel_pkg::TMR_W-1:0] seek_tmr_r, recal_tmr_r;
   logic [drive_panel_pkg::NFC-1:0] fault_r, fault_nxt, fault_set;
   logic [drive_panel_pkg::NEV-1:0] ev, irq_stat_r, irq_stat_nxt, irq_en_r, irq_clr;
   logic         ctrl_wp_r;
   logic [drive_panel_pkg::AW-1:0] addr_q_r;
   logic         wr_q_r;
   logic [31:0]  rd_word;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   assign pin_raw = {unit_sw, host_select, ac_power_ok, pack_det_fault,
                     board_unplugged, carriage_blocked, psu_fail, servo_lost,
                     rw_fault, recal_busy, seek_busy, heads_retracted,
                     heads_loaded, spindle_at_speed, spindle_stopped,
                     read_only_sw, run_sw};

   // Three stages; a bit moves only once stages two and three agree
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         in_r <= '0;
      end
      else
      begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         in_r <= (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & in_r);
      end
   end

   assign run_s     = in_r[drive_panel_pkg::IN_RUN];
   assign stopped_s = in_r[drive_panel_pkg::IN_STOPPED];
   assign speed_s   = in_r[drive_panel_pkg::IN_SPEED];
   assign loaded_s  = in_r[drive_panel_pkg::IN_LOADED];
   assign unit_s    = in_r[drive_panel_pkg::IN_UNIT_LSB +: drive_panel_pkg::UNIT_W];
   assign run_rise  = run_s & ~run_prev_r;

   // ----------------------------------------
   // Timeout counters
   // ----------------------------------------
   // Saturating count while busy, back to zero when idle
   function automatic logic [drive_panel_pkg::TMR_W-1:0] tmr_step(
      input logic [drive_panel_pkg::TMR_W-1:0] cnt,
      input logic                              busy);
      logic [drive_panel_pkg::TMR_W-1:0] nxt;
      nxt = '0;
      if (busy && (cnt != '1))
         nxt = cnt + 1'b1;
      else if (busy)
         nxt = cnt;
      return nxt;
   endfunction

   // Restart at operation start, clear to zero at its end
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         seek_tmr_r  <= '0;
         recal_tmr_r <= '0;
      end
      else
      begin
         seek_tmr_r  <= tmr_step(seek_tmr_r, in_r[drive_panel_pkg::IN_SEEK]);
         recal_tmr_r <= tmr_step(recal_tmr_r, in_r[drive_panel_pkg::IN_RECAL]);
      end
   end

   // ----------------------------------------
   // Fault latch
   // ----------------------------------------
   // Limit widths matched to the counters on purpose
   always_comb
   begin
      fault_set = '0;
      fault_set[drive_panel_pkg::FC_SEEK] = in_r[drive_panel_pkg::IN_SEEK] &&
         (seek_tmr_r == drive_panel_pkg::TMR_W'(SEEK_LIMIT - 1));
      fault_set[drive_panel_pkg::FC_RECAL] = in_r[drive_panel_pkg::IN_RECAL] &&
         (recal_tmr_r == drive_panel_pkg::TMR_W'(RECAL_LIMIT - 1));
      fault_set[drive_panel_pkg::FC_RW]    = in_r[drive_panel_pkg::IN_RWF];
      fault_set[drive_panel_pkg::FC_SERVO] = in_r[drive_panel_pkg::IN_SERVO];
      fault_set[drive_panel_pkg::FC_PSU]   = in_r[drive_panel_pkg::IN_PSU];
      fault_set[drive_panel_pkg::FC_CB]    = in_r[drive_panel_pkg::IN_CB];
      fault_set[drive_panel_pkg::FC_PCA]   = in_r[drive_panel_pkg::IN_PCA];
      // A standing fault survives the run edge: set wins over clear
      fault_nxt = (run_rise ? '0 : fault_r) | fault_set;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         fault_r    <= '0;
         run_prev_r <= 1'b0;
      end
      else
      begin
         fault_r    <= fault_nxt;
         run_prev_r <= run_s;
      end
   end

   // ----------------------------------------
   // Start and stop sequencer
   // ----------------------------------------
   // A latched fault in ST_LOAD or ST_READY takes the heads off and spins down, like a stop
   always_comb
   begin
      seq_nxt = seq_r;
      unique case (seq_r)
         drive_panel_pkg::ST_STOPPED:
            if (run_s)
               seq_nxt = drive_panel_pkg::ST_SPINUP;
         drive_panel_pkg::ST_SPINUP:
            if (!run_s)
               seq_nxt = drive_panel_pkg::ST_BRAKE;
            else if (speed_s)
               seq_nxt = drive_panel_pkg::ST_LOAD;
         drive_panel_pkg::ST_LOAD:
            if (!run_s || (|fault_r))
               seq_nxt = drive_panel_pkg::ST_RETRACT;
            else if (loaded_s)
               seq_nxt = drive_panel_pkg::ST_READY;
         drive_panel_pkg::ST_READY:
            if (!run_s || (|fault_r))
               seq_nxt = drive_panel_pkg::ST_RETRACT;
         drive_panel_pkg::ST_RETRACT:
            if (in_r[drive_panel_pkg::IN_RETRACT])
               seq_nxt = drive_panel_pkg::ST_BRAKE;
         drive_panel_pkg::ST_BRAKE:
            if (stopped_s)
               seq_nxt = drive_panel_pkg::ST_STOPPED;
         default:
            seq_nxt = drive_panel_pkg::ST_BRAKE;
      endcase
   end

   // Motor, head and door drive, registered from the next state
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         seq_r              <= drive_panel_pkg::ST_BRAKE;
         spindle_power      <= 1'b0;
         spindle_brake      <= 1'b0;
         head_load          <= 1'b0;
         head_retract       <= 1'b0;
         door_solenoid      <= 1'b0;
         door_unlocked_lamp <= 1'b0;
         drive_ready_lamp   <= 1'b0;
      end
      else
      begin
         seq_r <= seq_nxt;
         spindle_power <= (seq_nxt == drive_panel_pkg::ST_SPINUP) ||
                          (seq_nxt == drive_panel_pkg::ST_LOAD) ||
                          (seq_nxt == drive_panel_pkg::ST_READY);
         spindle_brake <= (seq_nxt == drive_panel_pkg::ST_BRAKE);
         head_load     <= (seq_nxt == drive_panel_pkg::ST_LOAD);
         head_retract  <= (seq_nxt == drive_panel_pkg::ST_RETRACT);
         door_solenoid <= (seq_nxt == drive_panel_pkg::ST_STOPPED) &&
                          !run_s && stopped_s;
         door_unlocked_lamp <= (seq_nxt == drive_panel_pkg::ST_STOPPED) &&
                               !run_s && stopped_s;
         drive_ready_lamp <= (seq_nxt == drive_panel_pkg::ST_READY) &&
                             speed_s && loaded_s;
      end
   end

   // ----------------------------------------
   // Panel lamps and display
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         drive_fault_lamp <= 1'b0;
         read_only_lamp   <= 1'b0;
         write_inhibit    <= 1'b1;
         unit_digit       <= '0;
         unit_display_on  <= 1'b0;
         select_lamp      <= 1'b0;
      end
      else
      begin
         drive_fault_lamp <= |fault_nxt;
         read_only_lamp   <= in_r[drive_panel_pkg::IN_RO];
         // Software may add protection but never lift the switch's
         write_inhibit    <= in_r[drive_panel_pkg::IN_RO] | ctrl_wp_r;
         unit_digit <= in_r[drive_panel_pkg::IN_PACKF] ? drive_panel_pkg::DIGIT_EIGHT
                       : drive_panel_pkg::DIGIT_W'(unit_s);
         unit_display_on  <= in_r[drive_panel_pkg::IN_AC];
         select_lamp      <= in_r[drive_panel_pkg::IN_SEL];
      end
   end

   // ----------------------------------------
   // Interrupt status, clear and enable
   // ----------------------------------------
   always_comb
   begin
      ev = '0;
      ev[drive_panel_pkg::EV_FAULT]  = (|fault_nxt) && !drive_fault_lamp;
      ev[drive_panel_pkg::EV_READY]  = (seq_nxt == drive_panel_pkg::ST_READY) &&
                                       speed_s && loaded_s && !drive_ready_lamp;
      ev[drive_panel_pkg::EV_DOOR]   = (seq_nxt == drive_panel_pkg::ST_STOPPED) &&
                                       !run_s && stopped_s && !door_unlocked_lamp;
      ev[drive_panel_pkg::EV_SELECT] = in_r[drive_panel_pkg::IN_SEL] && !select_lamp;
      irq_clr = '0;
      if (wr_q_r && (addr_q_r == drive_panel_pkg::REG_IRQ_CLR))
         irq_clr = hwdata[drive_panel_pkg::NEV-1:0];
      // New event beats a clear in the same cycle
      irq_stat_nxt = (irq_stat_r & ~irq_clr) | ev;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         irq_stat_r <= '0;
         irq        <= 1'b0;
      end
      else
      begin
         irq_stat_r <= irq_stat_nxt;
         irq        <= |(irq_stat_nxt & irq_en_r);
      end
   end

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   // Zero wait states; read data is sampled at the address phase
   always_comb
   begin
      rd_word = '0;
      unique case (haddr[drive_panel_pkg::AW-1:0])
         drive_panel_pkg::REG_CTRL:     rd_word[drive_panel_pkg::CTRL_WP] = ctrl_wp_r;
         drive_panel_pkg::REG_STATUS:   rd_word[14:0] = {unit_digit, select_lamp,
                                           read_only_lamp, drive_fault_lamp,
                                           drive_ready_lamp, door_unlocked_lamp,
                                           unit_display_on, 3'(seq_r), run_s, write_inhibit};
         drive_panel_pkg::REG_FAULT:    rd_word[drive_panel_pkg::NFC-1:0] = fault_r;
         drive_panel_pkg::REG_IRQ_STAT: rd_word[drive_panel_pkg::NEV-1:0] = irq_stat_r;
         drive_panel_pkg::REG_IRQ_EN:   rd_word[drive_panel_pkg::NEV-1:0] = irq_en_r;
         default:                       rd_word = '0;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         addr_q_r  <= '0;
         wr_q_r    <= 1'b0;
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_q_r    <= hsel && hready && (htrans == drive_panel_pkg::HTRANS_NONSEQ) && hwrite;
         addr_q_r  <= haddr[drive_panel_pkg::AW-1:0];
         if (hsel && hready && (htrans == drive_panel_pkg::HTRANS_NONSEQ) && !hwrite)
            hrdata <= rd_word;
      end
   end

   // Software-written control and enable registers
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ctrl_wp_r <= 1'b0;
         irq_en_r  <= '0;
      end
      else if (wr_q_r)
      begin
         if (addr_q_r == drive_panel_pkg::REG_CTRL)
            ctrl_wp_r <= hwdata[drive_panel_pkg::CTRL_WP];
         if (addr_q_r == drive_panel_pkg::REG_IRQ_EN)
            irq_en_r <= hwdata[drive_panel_pkg::NEV-1:0];
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   chk_seek_timeout: assert property (in_r[drive_panel_pkg::IN_SEEK] &&
      seek_tmr_r == drive_panel_pkg::TMR_W'(SEEK_LIMIT - 1) |=> drive_fault_lamp &&
      fault_r[drive_panel_pkg::FC_SEEK]) else $error("seek timeout not latched");
   chk_recal_timeout: assert property (in_r[drive_panel_pkg::IN_RECAL] &&
      recal_tmr_r == drive_panel_pkg::TMR_W'(RECAL_LIMIT - 1) |=> drive_fault_lamp &&
      fault_r[drive_panel_pkg::FC_RECAL]) else $error("recal timeout not latched");
   chk_fault_sources: assert property (|fault_set[drive_panel_pkg::NFC-1:drive_panel_pkg::FC_RW]
      |=> drive_fault_lamp) else $error("fault source missed");
   chk_timer_idle: assert property (!in_r[drive_panel_pkg::IN_SEEK]
      |=> seek_tmr_r == '0 ##1 (seek_tmr_r <= 1)) else $error("seek timer not restarted");
   chk_door_safe: assert property (door_unlocked_lamp
      |-> $past(!run_s && stopped_s) && door_solenoid) else $error("door unlocked unsafely");
   chk_ready_gate: assert property (drive_ready_lamp
      |-> $past(speed_s && loaded_s) && !head_retract) else $error("ready without heads");
   chk_run_clears: assert property (run_rise && !(|fault_set)
      |=> fault_r == '0 && !door_solenoid) else $error("run did not clear faults");
   chk_stop_retract: assert property (seq_r == drive_panel_pkg::ST_READY && !run_s
      |=> head_retract && !spindle_power) else $error("stop did not retract");
   chk_pack_eight: assert property (in_r[drive_panel_pkg::IN_PACKF]
      |=> unit_digit == drive_panel_pkg::DIGIT_EIGHT) else $error("pack fault digit");
   chk_unit_match: assert property (!in_r[drive_panel_pkg::IN_PACKF]
      |=> unit_digit == drive_panel_pkg::DIGIT_W'($past(unit_s))) else $error("digit mismatch");
   chk_read_only: assert property (in_r[drive_panel_pkg::IN_RO]
      |=> write_inhibit && read_only_lamp) else $error("read-only not enforced");
   chk_select_lamp: assert property ($rose(in_r[drive_panel_pkg::IN_SEL])
      |=> select_lamp) else $error("select lamp late");

   cov_ready:  cover property (drive_ready_lamp);
   cov_fault:  cover property ($rose(drive_fault_lamp));
   cov_door:   cover property ($rose(door_unlocked_lamp));
   cov_irq:    cover property ($rose(irq));
endmodule

// ===== verification/spindle_mech.sv
// Behavioural spindle and carriage that answer the panel's motor and head commands.
// Assumes registered command levels on mclk; speed ramps over 15 cycles.
`timescale 1ns/1ps
module spindle_mech (
   input  wire logic mclk,             // Clock
   input  wire logic spindle_power,    // Motor on
   input  wire logic spindle_brake,    // Brake on
   input  wire logic head_load,        // Load command
   input  wire logic head_retract,     // Retract command
   output logic      spindle_stopped,  // At rest
   output logic      spindle_at_speed, // Full speed
   output logic      heads_loaded,     // On cylinder zero
   output logic      heads_retracted   // Carriage home
);
   logic [3:0] spin_r = 4'h0;
   logic       load_r = 1'b0;
   // Unbraked spindle never slows, so a missing brake keeps the door shut
   always_ff @(posedge mclk)
   begin
      if (spindle_power && spin_r != 4'hF)
         spin_r <= spin_r + 4'h1;
      else if (!spindle_power && spindle_brake && spin_r != 4'h0)
         spin_r <= spin_r - 4'h1;
   end
   // Heads fly only over a spindle at full speed
   always_ff @(posedge mclk)
   begin
      if (head_load && !head_retract && spin_r == 4'hF)
         load_r <= 1'b1;
      else if (head_retract && !head_load)
         load_r <= 1'b0;
   end
   // Sensors report the mechanical state
   assign spindle_stopped  = (spin_r == 4'h0);
   assign spindle_at_speed = (spin_r == 4'hF);
   assign heads_loaded     = load_r;
   assign heads_retracted  = !load_r;
endmodule

// ===== verification/drive_panel_test.sv
// Self-checking bench: AHB-Lite reads are checked against a queue of expected words.
// Assumes spindle_mech answers the motor and head commands of the block.
`timescale 1ns/1ps
module drive_panel_test;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        rd_phase = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic [31:0] exp_q[$];
   logic        hreadyout, irq, select_lamp, pwr, brk, hld, hrt, stp, spd, ldd, rtd;
   logic        run_sw = 1'b0, read_only_sw = 1'b0, seek_busy = 1'b0, rw_fault = 1'b0;
   logic        pack_det_fault = 1'b0, host_select = 1'b0, cb = 1'b0, ac = 1'b1;
   logic        rcb = 1'b0, psu = 1'b0, hresp, sol, dsp;
   logic [2:0]  unit_sw = 3'h5;
   logic [7:0]  rnd = 8'h3A;
   int          err_count = 0, samples_checked = 0, cyc = 0;
   // ----------------------------------------
   // Design, mechanism and clock
   // ----------------------------------------
   drive_panel #(.SEEK_LIMIT(20), .RECAL_LIMIT(50)) dut_u (.mclk(mclk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .run_sw(run_sw),
      .read_only_sw(read_only_sw), .spindle_stopped(stp), .spindle_at_speed(spd),
      .heads_loaded(ldd), .heads_retracted(rtd), .seek_busy(seek_busy), .recal_busy(rcb),
      .rw_fault(rw_fault), .servo_lost(1'b0), .psu_fail(psu), .carriage_blocked(cb),
      .board_unplugged(1'b0), .pack_det_fault(pack_det_fault), .ac_power_ok(ac),
      .host_select(host_select), .unit_sw(unit_sw), .spindle_power(pwr), .spindle_brake(brk),
      .head_load(hld), .head_retract(hrt), .door_solenoid(sol), .door_unlocked_lamp(),
      .drive_ready_lamp(), .drive_fault_lamp(), .read_only_lamp(), .write_inhibit(),
      .unit_digit(), .unit_display_on(dsp), .select_lamp(select_lamp), .irq(irq));
   spindle_mech mech_u (.mclk(mclk), .spindle_power(pwr), .spindle_brake(brk), .head_load(hld),
      .head_retract(hrt), .spindle_stopped(stp), .spindle_at_speed(spd), .heads_loaded(ldd),
      .heads_retracted(rtd));
   initial
   begin
      forever #4 mclk = ~mclk;
   end
   // Expected status word: digit, state, read-only, inhibit, run, door, ready, fault, select
   function automatic logic [31:0] stw(input logic [3:0] dg, input logic [2:0] st,
      input logic ro, wi, rn, dr, rdy, flt, sl);
      stw = {17'h0_0000, dg, sl, ro, flt, rdy, dr, 1'b1, st, rn, wi};
   endfunction
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   // One single-word transfer; hready is waited for, never assumed
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      rd_phase <= !w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd_phase <= 1'b0;
      hsel <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(a, 1'b0, 32'h0000_0000);
   endtask
   task automatic chk(input string n, input logic got, input logic e);
      samples_checked++;
      if (got !== e)
      begin
         err_count++;
         $display("ERROR %s expected %b seen %b", n, e, got);
      end
   endtask
   task automatic give_verdict;
      if (err_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Read data taken at the end of each data phase, oldest note first
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         give_verdict();
      end
      if (rd_phase)
      begin
         samples_checked++;
         // Response code rides along with the data: always OKAY
         if ({hresp, hrdata} !== {1'b0, exp_q[0]})
         begin
            err_count++;
            $display("ERROR hrdata expected %h seen %h", {1'b0, exp_q[0]}, {hresp, hrdata});
         end
         void'(exp_q.pop_front());
      end
   end
   // Main sequence
   initial
   begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (40) @(posedge mclk);
      rd(8'h0C, 32'h0000_0004);
      bus(8'h10, 1'b1, 32'h0000_000F);
      bus(8'h14, 1'b1, 32'h0000_0002);
      rd(8'h40, 32'h0000_0000);
      for (int i = 0; i < 4; i++)
      begin
         rnd = lfsr(rnd);
         unit_sw <= rnd[2:0];
         read_only_sw <= rnd[3];
         pack_det_fault <= rnd[4];
         repeat (8) @(posedge mclk);
         rd(8'h04, stw(rnd[4] ? 4'h8 : {1'b0, rnd[2:0]}, 3'h0, rnd[3], rnd[3], 1'b0, 1'b1,
            1'b0, 1'b0, 1'b0));
      end
      unit_sw <= 3'h5;
      read_only_sw <= 1'b0;
      pack_det_fault <= 1'b0;
      bus(8'h00, 1'b1, 32'h0000_0001);
      repeat (8) @(posedge mclk);
      rd(8'h04, stw(4'h5, 3'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
      bus(8'h00, 1'b1, 32'h0000_0000);
      run_sw <= 1'b1;
      repeat (80) @(posedge mclk);
      rd(8'h04, stw(4'h5, 3'h3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
      @(negedge mclk) chk("irq", irq, 1'b1);
      bus(8'h10, 1'b1, 32'h0000_0002);
      repeat (4) @(posedge mclk);
      @(negedge mclk) chk("irq", irq, 1'b0);
      @(posedge mclk);
      host_select <= 1'b1;
      seek_busy <= 1'b1;
      repeat (15) @(posedge mclk);
      seek_busy <= 1'b0;
      repeat (10) @(posedge mclk);
      rd(8'h08, 32'h0000_0000);
      seek_busy <= 1'b1;
      repeat (30) @(posedge mclk);
      seek_busy <= 1'b0;
      @(negedge mclk) chk("select_lamp", select_lamp, 1'b1);
      @(posedge mclk);
      run_sw <= 1'b0;
      repeat (80) @(posedge mclk);
      rd(8'h08, 32'h0000_0001);
      rd(8'h04, stw(4'h5, 3'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1));
      @(negedge mclk) chk("door_solenoid", sol, 1'b1);
      @(posedge mclk);
      run_sw <= 1'b1;
      repeat (80) @(posedge mclk);
      rd(8'h08, 32'h0000_0000);
      rw_fault <= 1'b1;
      cb <= 1'b1;
      psu <= 1'b1;
      repeat (8) @(posedge mclk);
      rd(8'h08, 32'h0000_0034);
      rcb <= 1'b1;
      repeat (60) @(posedge mclk);
      rd(8'h08, 32'h0000_0036);
      ac <= 1'b0;
      repeat (8) @(posedge mclk);
      @(negedge mclk) chk("unit_display_on", dsp, 1'b0);
      // Let the last data-phase compare run before the report
      @(posedge mclk);
      give_verdict();
   end
endmodule
